// ### shared/hsm_consts.svh
// hsm_consts.svh: offsets, codes, reset values and timing counts of the stage mode control block
// assumes a 10 MHz core clock; included by the design file, the checker, the supervisor model and the bench
`ifndef HSM_CONSTS_SVH
`define HSM_CONSTS_SVH

// register offsets
`define HSM_ADDR_SCHEME 8'h00
`define HSM_ADDR_LOCK 8'h04
`define HSM_ADDR_HEAT_FAN 8'h08
`define HSM_ADDR_LOW_SPEED 8'h0C
`define HSM_ADDR_FAN_MODE 8'h10
`define HSM_ADDR_SYS_MODE 8'h14
`define HSM_ADDR_ASSIGNED 8'h18
`define HSM_ADDR_HEARTBEAT 8'h1C
`define HSM_ADDR_HB_PERIOD 8'h20
`define HSM_ADDR_OCC_COOL 8'h24
`define HSM_ADDR_OCC_HEAT 8'h28
`define HSM_ADDR_UNOCC_COOL 8'h2C
`define HSM_ADDR_UNOCC_HEAT 8'h30
`define HSM_ADDR_DEADBAND 8'h34
`define HSM_ADDR_SHOWN 8'h38
`define HSM_ADDR_NET_OUT 8'h3C
`define HSM_ADDR_STATUS 8'h40
`define HSM_ADDR_CUR_TEMP 8'h44

// control scheme codes
`define HSM_SCHEME_AUTO 3'h1
`define HSM_SCHEME_MANUAL 3'h2
`define HSM_SCHEME_COOL_ONLY 3'h3
`define HSM_SCHEME_HEAT_ONLY 3'h4

// field positions
`define HSM_LOCK_NET_BIT 9
`define HSM_LOCK_MODE_BTN_BIT 1
`define HSM_LOCK_FAN_BTN_BIT 2
`define HSM_LOCK_SET_BTN_BIT 3

// codes
`define HSM_SPEED_STOP 2'h1
`define HSM_SPEED_LOW 2'h2
`define HSM_FAN_AUTO 2'h1
`define HSM_FAN_CONT 2'h2

// reset values and the stage-two band
`define HSM_RST_LOCK 16'h0000
`define HSM_RST_HB_PERIOD 16'h003C
`define HSM_RST_OCC_COOL 16'h00F0
`define HSM_RST_OCC_HEAT 16'h00D2
`define HSM_RST_UNOCC_COOL 16'h0118
`define HSM_RST_UNOCC_HEAT 16'h00B4
`define HSM_RST_DEADBAND 16'h0014
`define HSM_AUTO_BAND 16'h000A

// timing
`define HSM_CLK_HZ 10000000
`define HSM_TICK_CYCLES (`HSM_CLK_HZ / 1)
`define HSM_FAN_OFF_SEC 120
`define HSM_FLASH_BIT 0
`define HSM_SYNC_DEPTH 2'h2

`endif

// ### shared/hsm_pkg.sv
// hsm_pkg.sv: types of the stage mode control block
// assumes hsm_consts.svh sits beside it on the include path
package hsm_pkg;

    typedef enum logic [1:0] {
        HSM_WM_MAIN = 2'b00,
        HSM_WM_VENT = 2'b01
    } hsm_work_t;

    typedef enum logic [1:0] {
        HSM_UI_IDLE = 2'b00,
        HSM_UI_MODE = 2'b01,
        HSM_UI_OCC = 2'b11
    } hsm_ui_t;

    typedef struct packed {
        logic mode;
        logic fan;
        logic up;
        logic down;
        logic set;
    } hsm_btn_t;

    typedef struct packed {
        logic cool1;
        logic cool2;
        logic heat1;
        logic heat2;
        logic fan;
    } hsm_out_t;

    typedef struct packed {
        logic active;
        logic stage1;
        logic stage2;
        logic auto_icon;
        logic fan_spin;
        logic unocc;
        logic heat_mode;
        logic vent;
    } hsm_ind_t;

    typedef struct packed {
        logic [2:0] scheme;
        logic [15:0] lock;
        logic heat_fan;
        logic [1:0] low_speed;
        logic [1:0] fan_mode;
        logic heat_mode;
        hsm_work_t work;
        logic [15:0] assigned;
        logic hb_last;
        logic [15:0] hb_period;
        logic [15:0] hb_count;
        logic hb_valid;
        logic [15:0] occ_cool;
        logic [15:0] occ_heat;
        logic [15:0] unocc_cool;
        logic [15:0] unocc_heat;
        logic [15:0] deadband;
        logic shown;
        hsm_out_t net_out;
        hsm_out_t outs;
        logic [23:0] pre;
        logic tick;
        logic [7:0] fan_off;
        logic fan_hold;
        logic was_call;
        logic flash;
        logic [1:0] warm;
        hsm_ui_t ui;
        logic occ_pending;
        logic unocc;
        hsm_btn_t btn_s1;
        hsm_btn_t btn_s2;
        hsm_btn_t btn_last;
        logic [15:0] sens_s1;
        logic [15:0] sens_s2;
        logic [15:0] cur_temp;
        logic [15:0] shown_value;
        hsm_ind_t ind;
        logic [31:0] rdata;
    } hsm_state_t;

endpackage

// ### src/hsm_stage_mode_ctrl.sv
// hsm_stage_mode_ctrl.sv: control scheme, stage outputs, fan gating, fan-off delay, heartbeat
// assumes buttons and sensor are asynchronous; register port is on the core clock
`timescale 1ns/1ps
`include "hsm_consts.svh"

module hsm_stage_mode_ctrl (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // panel and sensor
    input wire hsm_pkg::hsm_btn_t i_btn,
    input wire logic [15:0] i_sensor_temp,
    // equipment outputs and indicators
    output hsm_pkg::hsm_out_t o_outs,
    output hsm_pkg::hsm_ind_t o_ind,
    output logic [15:0] o_shown_value
);

    hsm_pkg::hsm_state_t s_reg;
    hsm_pkg::hsm_state_t s_next;
    // next-state temporaries
    hsm_pkg::hsm_btn_t press;
    logic [15:0] cool_sp;
    logic [15:0] heat_sp;
    logic [15:0] temp;
    logic cool_call1;
    logic cool_call2;
    logic heat_call1;
    logic heat_call2;
    logic call;
    logic fan_run;
    logic hb_toggle;
    logic warm_ok;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // no changeover or call until the sensor synchroniser holds a real sample
        warm_ok = (s_reg.warm == `HSM_SYNC_DEPTH);
        if (!warm_ok) begin
            s_next.warm = s_reg.warm + 2'h1;
        end
        press = s_reg.btn_s2 & ~s_reg.btn_last;
        s_next.btn_s1 = i_btn;
        s_next.btn_s2 = s_reg.btn_s1;
        s_next.btn_last = s_reg.btn_s2;
        s_next.sens_s1 = i_sensor_temp;
        s_next.sens_s2 = s_reg.sens_s1;
        hb_toggle = 1'b0;

        // one-second tick
        s_next.tick = 1'b0;
        if (s_reg.pre == 24'(`HSM_TICK_CYCLES - 1)) begin
            s_next.pre = 24'h000000;
            s_next.tick = 1'b1;
        end else begin
            s_next.pre = s_reg.pre + 24'h000001;
        end

        // register writes
        if (i_wr) begin
            if (i_addr == `HSM_ADDR_SCHEME) begin
                if (i_wdata[2:0] == `HSM_SCHEME_AUTO || i_wdata[2:0] == `HSM_SCHEME_MANUAL) begin
                    s_next.scheme = i_wdata[2:0];
                end
            end else if (i_addr == `HSM_ADDR_LOCK) begin
                s_next.lock = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_HEAT_FAN) begin
                s_next.heat_fan = i_wdata[0];
            end else if (i_addr == `HSM_ADDR_LOW_SPEED) begin
                if (i_wdata[1:0] == `HSM_SPEED_STOP || i_wdata[1:0] == `HSM_SPEED_LOW) begin
                    s_next.low_speed = i_wdata[1:0];
                end
            end else if (i_addr == `HSM_ADDR_FAN_MODE) begin
                if (i_wdata[1:0] == `HSM_FAN_AUTO || i_wdata[1:0] == `HSM_FAN_CONT) begin
                    s_next.fan_mode = i_wdata[1:0];
                end
            end else if (i_addr == `HSM_ADDR_SYS_MODE) begin
                if (s_reg.scheme == `HSM_SCHEME_MANUAL) begin
                    s_next.heat_mode = i_wdata[0];
                end
            end else if (i_addr == `HSM_ADDR_ASSIGNED) begin
                s_next.assigned = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_HEARTBEAT) begin
                hb_toggle = (i_wdata[0] != s_reg.hb_last);
                s_next.hb_last = i_wdata[0];
            end else if (i_addr == `HSM_ADDR_HB_PERIOD) begin
                s_next.hb_period = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_OCC_COOL) begin
                s_next.occ_cool = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_OCC_HEAT) begin
                s_next.occ_heat = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_UNOCC_COOL) begin
                s_next.unocc_cool = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_UNOCC_HEAT) begin
                s_next.unocc_heat = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_DEADBAND) begin
                s_next.deadband = i_wdata[15:0];
            end else if (i_addr == `HSM_ADDR_SHOWN) begin
                s_next.shown = i_wdata[0];
            end else if (i_addr == `HSM_ADDR_NET_OUT) begin
                s_next.net_out = i_wdata[4:0];
            end
        end

        // heartbeat supervision
        if (hb_toggle) begin
            s_next.hb_count = 16'h0000;
            s_next.hb_valid = 1'b1;
        end else if (s_reg.tick && s_reg.hb_valid) begin
            if (s_reg.hb_count + 16'h0001 >= s_reg.hb_period) begin
                s_next.hb_valid = 1'b0;
            end else begin
                s_next.hb_count = s_reg.hb_count + 16'h0001;
            end
        end
        temp = s_reg.hb_valid ? s_reg.assigned : s_reg.sens_s2;
        s_next.cur_temp = temp;

        // panel: mode, fan and occupancy buttons
        case (s_reg.ui)
            hsm_pkg::HSM_UI_IDLE: begin
                if (press.mode && !s_reg.lock[`HSM_LOCK_MODE_BTN_BIT]) begin
                    s_next.ui = hsm_pkg::HSM_UI_MODE;
                end else if (press.set && !s_reg.lock[`HSM_LOCK_SET_BTN_BIT]) begin
                    s_next.ui = hsm_pkg::HSM_UI_OCC;
                    s_next.occ_pending = s_reg.unocc;
                end
            end
            hsm_pkg::HSM_UI_MODE: begin
                if (press.up || press.down) begin
                    // heat/cool main, then vent; manual scheme also swaps heat and cool
                    if (s_reg.scheme == `HSM_SCHEME_MANUAL && s_reg.work == hsm_pkg::HSM_WM_VENT) begin
                        s_next.heat_mode = ~s_reg.heat_mode;
                        s_next.work = hsm_pkg::HSM_WM_MAIN;
                    end else begin
                        s_next.work = (s_reg.work == hsm_pkg::HSM_WM_MAIN) ?
                            hsm_pkg::HSM_WM_VENT : hsm_pkg::HSM_WM_MAIN;
                    end
                end else if (press.mode || press.set) begin
                    s_next.ui = hsm_pkg::HSM_UI_IDLE;
                end
            end
            hsm_pkg::HSM_UI_OCC: begin
                if (press.up || press.down) begin
                    s_next.occ_pending = ~s_reg.occ_pending;
                end else if (press.set || press.mode) begin
                    s_next.unocc = s_reg.occ_pending;
                    s_next.ui = hsm_pkg::HSM_UI_IDLE;
                end
            end
            default: begin
                s_next.ui = hsm_pkg::HSM_UI_IDLE;
            end
        endcase
        if (press.fan && !s_reg.lock[`HSM_LOCK_FAN_BTN_BIT]) begin
            s_next.fan_mode = (s_reg.fan_mode == `HSM_FAN_AUTO) ? `HSM_FAN_CONT : `HSM_FAN_AUTO;
        end

        // automatic changeover and stage calls
        cool_sp = s_reg.unocc ? s_reg.unocc_cool : s_reg.occ_cool;
        heat_sp = s_reg.unocc ? s_reg.unocc_heat : s_reg.occ_heat;
        if (s_reg.scheme == `HSM_SCHEME_AUTO && warm_ok) begin
            if (s_reg.heat_mode && temp > cool_sp) begin
                s_next.heat_mode = 1'b0;
            end else if (!s_reg.heat_mode && temp < heat_sp) begin
                s_next.heat_mode = 1'b1;
            end
        end
        cool_call1 = warm_ok && !s_reg.heat_mode && s_reg.work == hsm_pkg::HSM_WM_MAIN && temp > cool_sp;
        cool_call2 = cool_call1 && temp > cool_sp + `HSM_AUTO_BAND;
        heat_call1 = warm_ok && s_reg.heat_mode && s_reg.work == hsm_pkg::HSM_WM_MAIN && temp < heat_sp;
        heat_call2 = heat_call1 && temp + `HSM_AUTO_BAND < heat_sp;
        call = cool_call1 || heat_call1;
        s_next.was_call = call;

        // fan-off delay after a control action
        if (call) begin
            s_next.fan_hold = 1'b0;
            s_next.fan_off = 8'h00;
        end else if (s_reg.was_call && s_reg.low_speed == `HSM_SPEED_STOP) begin
            s_next.fan_hold = 1'b1;
            s_next.fan_off = 8'h00;
        end else if (s_reg.was_call && s_reg.low_speed == `HSM_SPEED_LOW) begin
            s_next.fan_hold = 1'b1;
        end else if (s_reg.fan_hold && s_reg.low_speed == `HSM_SPEED_STOP && s_reg.tick) begin
            if (s_reg.fan_off == 8'(`HSM_FAN_OFF_SEC - 1)) begin
                s_next.fan_hold = 1'b0;
            end else begin
                s_next.fan_off = s_reg.fan_off + 8'h01;
            end
        end
        if (s_reg.tick) begin
            s_next.flash = ~s_reg.flash;
        end

        fan_run = (s_reg.fan_mode == `HSM_FAN_CONT) || s_reg.fan_hold ||
                  (call && s_reg.work == hsm_pkg::HSM_WM_MAIN) || s_reg.work == hsm_pkg::HSM_WM_VENT;
        if (s_reg.heat_mode && !s_reg.heat_fan) begin
            fan_run = 1'b0;
        end

        // output owner
        if (s_reg.lock[`HSM_LOCK_NET_BIT]) begin
            s_next.outs = s_reg.net_out;
        end else begin
            s_next.outs.cool1 = cool_call1;
            s_next.outs.cool2 = cool_call2;
            s_next.outs.heat1 = heat_call1;
            s_next.outs.heat2 = heat_call2;
            s_next.outs.fan = fan_run;
        end

        // indicators
        s_next.ind.active = s_reg.outs.cool1 | s_reg.outs.cool2 | s_reg.outs.heat1 | s_reg.outs.heat2;
        s_next.ind.stage1 = s_reg.outs.cool1 | s_reg.outs.heat1;
        s_next.ind.stage2 = s_reg.outs.cool2 | s_reg.outs.heat2;
        s_next.ind.auto_icon = (s_reg.fan_mode == `HSM_FAN_AUTO) &&
                               !(s_reg.fan_hold && s_reg.low_speed == `HSM_SPEED_STOP && s_reg.flash);
        s_next.ind.fan_spin = s_reg.outs.fan;
        s_next.ind.unocc = s_reg.unocc;
        s_next.ind.heat_mode = s_reg.heat_mode;
        s_next.ind.vent = (s_reg.work == hsm_pkg::HSM_WM_VENT);
        s_next.shown_value = s_reg.shown ? (s_reg.heat_mode ? heat_sp : cool_sp) : temp;

        // register reads
        s_next.rdata = 32'h00000000;
        if (i_rd) begin
            if (i_addr == `HSM_ADDR_SCHEME) begin
                s_next.rdata = {29'h0, s_reg.scheme};
            end else if (i_addr == `HSM_ADDR_LOCK) begin
                s_next.rdata = {16'h0, s_reg.lock};
            end else if (i_addr == `HSM_ADDR_HEAT_FAN) begin
                s_next.rdata = {31'h0, s_reg.heat_fan};
            end else if (i_addr == `HSM_ADDR_LOW_SPEED) begin
                s_next.rdata = {30'h0, s_reg.low_speed};
            end else if (i_addr == `HSM_ADDR_FAN_MODE) begin
                s_next.rdata = {30'h0, s_reg.fan_mode};
            end else if (i_addr == `HSM_ADDR_SYS_MODE) begin
                s_next.rdata = {31'h0, s_reg.heat_mode};
            end else if (i_addr == `HSM_ADDR_ASSIGNED) begin
                s_next.rdata = {16'h0, s_reg.assigned};
            end else if (i_addr == `HSM_ADDR_HEARTBEAT) begin
                s_next.rdata = {31'h0, s_reg.hb_last};
            end else if (i_addr == `HSM_ADDR_HB_PERIOD) begin
                s_next.rdata = {16'h0, s_reg.hb_period};
            end else if (i_addr == `HSM_ADDR_OCC_COOL) begin
                s_next.rdata = {16'h0, s_reg.occ_cool};
            end else if (i_addr == `HSM_ADDR_OCC_HEAT) begin
                s_next.rdata = {16'h0, s_reg.occ_heat};
            end else if (i_addr == `HSM_ADDR_UNOCC_COOL) begin
                s_next.rdata = {16'h0, s_reg.unocc_cool};
            end else if (i_addr == `HSM_ADDR_UNOCC_HEAT) begin
                s_next.rdata = {16'h0, s_reg.unocc_heat};
            end else if (i_addr == `HSM_ADDR_DEADBAND) begin
                s_next.rdata = {16'h0, s_reg.deadband};
            end else if (i_addr == `HSM_ADDR_SHOWN) begin
                s_next.rdata = {31'h0, s_reg.shown};
            end else if (i_addr == `HSM_ADDR_NET_OUT) begin
                s_next.rdata = {27'h0, s_reg.net_out};
            end else if (i_addr == `HSM_ADDR_STATUS) begin
                s_next.rdata = {16'h0, 4'h0, s_reg.hb_valid, s_reg.fan_hold, s_reg.unocc,
                                s_reg.ind, s_reg.work == hsm_pkg::HSM_WM_VENT};
            end else if (i_addr == `HSM_ADDR_CUR_TEMP) begin
                s_next.rdata = {16'h0, s_reg.cur_temp};
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '0;
            s_reg.scheme <= `HSM_SCHEME_AUTO;
            s_reg.lock <= `HSM_RST_LOCK;
            s_reg.low_speed <= `HSM_SPEED_STOP;
            s_reg.fan_mode <= `HSM_FAN_AUTO;
            s_reg.hb_period <= `HSM_RST_HB_PERIOD;
            s_reg.occ_cool <= `HSM_RST_OCC_COOL;
            s_reg.occ_heat <= `HSM_RST_OCC_HEAT;
            s_reg.unocc_cool <= `HSM_RST_UNOCC_COOL;
            s_reg.unocc_heat <= `HSM_RST_UNOCC_HEAT;
            s_reg.deadband <= `HSM_RST_DEADBAND;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;
    assign o_outs = s_reg.outs;
    assign o_ind = s_reg.ind;
    assign o_shown_value = s_reg.shown_value;

endmodule // hsm_stage_mode_ctrl

// ### tb/hsm_stage_mode_ctrl_checker.sv
// hsm_stage_mode_ctrl_checker.sv: port assertions for the stage mode control block
// assumes it is bound onto hsm_stage_mode_ctrl, one core clock domain
`timescale 1ns/1ps
`include "hsm_consts.svh"

module hsm_stage_mode_ctrl_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // outputs
    input wire hsm_pkg::hsm_out_t o_outs,
    input wire hsm_pkg::hsm_ind_t o_ind
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    AST_ACTIVE_ON: assert property ((o_outs.cool1 | o_outs.cool2 | o_outs.heat1 | o_outs.heat2) |=> o_ind.active)
        else $error("activity indicator missing while a stage runs");
    AST_ACTIVE_OFF: assert property (!(o_outs.cool1 | o_outs.cool2 | o_outs.heat1 | o_outs.heat2) |=> !o_ind.active)
        else $error("activity indicator on with all stages off");
    AST_STAGE_ONE: assert property ((o_outs.cool1 | o_outs.heat1) |=> o_ind.stage1)
        else $error("stage one indicator missing");
    AST_STAGE_TWO: assert property ((o_outs.cool2 | o_outs.heat2) |=> o_ind.stage2)
        else $error("stage two indicator missing");
    AST_SPIN_ON: assert property (o_outs.fan |=> o_ind.fan_spin)
        else $error("fan indicator still while fan runs");
    AST_SPIN_OFF: assert property (!o_outs.fan |=> !o_ind.fan_spin)
        else $error("fan indicator moving with fan off");
    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    AST_SCHEME_LEGAL: assert property ((i_rd && i_addr == `HSM_ADDR_SCHEME) |=> o_rdata inside {32'h1, 32'h2})
        else $error("control scheme holds an unavailable code");
endmodule // hsm_stage_mode_ctrl_checker

// ### tb/hsm_sup_model.sv
// hsm_sup_model.sv: network supervisor, panel buttons and room sensor around the block
// assumes the block samples its register port on the rising core clock edge
`timescale 1ns/1ps
`include "hsm_consts.svh"

module hsm_sup_model (
    // clock
    input wire logic i_core_clk,
    // register port toward the block
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [31:0] i_rdata,
    // panel and sensor toward the block
    output hsm_pkg::hsm_btn_t o_btn,
    output logic [15:0] o_sensor_temp
);
    logic hb_bit;

    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_btn = '0;
        o_sensor_temp = 16'h00E0;
        hb_bit = 1'b0;
    end

    // object write; released data is scrambled so nothing leans on it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    // heartbeat object flip, sent well inside its period
    task automatic beat();
        hb_bit = ~hb_bit;
        wr(`HSM_ADDR_HEARTBEAT, {31'h0, hb_bit});
    endtask

    task automatic press(input logic [4:0] m);
        @(posedge i_core_clk);
        o_btn <= hsm_pkg::hsm_btn_t'(m);
        repeat (6) @(posedge i_core_clk);
        o_btn <= '0;
        repeat (6) @(posedge i_core_clk);
    endtask

    task automatic set_temp(input logic [15:0] t);
        @(posedge i_core_clk);
        o_sensor_temp <= t;
    endtask
endmodule // hsm_sup_model

// ### tb/tb_hsm_stage_mode_ctrl.sv
// tb_hsm_stage_mode_ctrl.sv: self-checking bench of the stage mode control block
// assumes the supervisor model and the bound checker sit beside it
`timescale 1ns/1ps
`include "hsm_consts.svh"

module tb_hsm_stage_mode_ctrl;
    logic i_core_clk;
    logic i_rst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    hsm_pkg::hsm_btn_t btn;
    logic [15:0] sensor;
    hsm_pkg::hsm_out_t outs;
    hsm_pkg::hsm_ind_t ind;
    logic [15:0] shown;
    int num_errors = 0;
    int check_count = 0;

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    hsm_stage_mode_ctrl hsm_stage_mode_ctrl_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_btn(btn), .i_sensor_temp(sensor), .o_outs(outs), .o_ind(ind),
        .o_shown_value(shown));
    hsm_sup_model hsm_sup_model_i (.i_core_clk(i_core_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
        .i_rdata(rdata), .o_btn(btn), .o_sensor_temp(sensor));

    // ----------------------------------------
    // compare and bus helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        hsm_sup_model_i.rd(a, d);
        chk($sformatf("register %h", a), exp, d);
    endtask

    // sensor sync, state and indicator stages all land within this
    task automatic settle();
        repeat (8) @(posedge i_core_clk);
        #1;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rchk(`HSM_ADDR_SCHEME, 32'h1);
        rchk(`HSM_ADDR_LOCK, 32'h0);
        rchk(`HSM_ADDR_HEAT_FAN, 32'h0);
        rchk(`HSM_ADDR_LOW_SPEED, 32'h1);
        rchk(`HSM_ADDR_FAN_MODE, 32'h1);
        rchk(`HSM_ADDR_OCC_COOL, 32'hF0);
        rchk(`HSM_ADDR_UNOCC_HEAT, 32'hB4);
        rchk(`HSM_ADDR_DEADBAND, 32'h14);
        rchk(8'h80, 32'h0);
        chk("auto icon", 32'h1, 32'(ind.auto_icon));
        $display("test reset done");
    endtask

    task automatic t_scheme();
        hsm_sup_model_i.wr(`HSM_ADDR_SCHEME, 32'h3);
        rchk(`HSM_ADDR_SCHEME, 32'h1);
        hsm_sup_model_i.wr(`HSM_ADDR_SCHEME, 32'h4);
        rchk(`HSM_ADDR_SCHEME, 32'h1);
        hsm_sup_model_i.wr(`HSM_ADDR_SCHEME, 32'h2);
        hsm_sup_model_i.press(5'h10);
        hsm_sup_model_i.press(5'h04);
        settle();
        chk("vent", 32'h1, 32'(ind.vent));
        hsm_sup_model_i.press(5'h02);
        hsm_sup_model_i.press(5'h10);
        rchk(`HSM_ADDR_SCHEME, 32'h2);
        chk("swap", 32'h2, {30'h0, ind.heat_mode, ind.vent});
        hsm_sup_model_i.wr(`HSM_ADDR_SYS_MODE, 32'h0);
        settle();
        chk("cool mode", 32'h0, 32'(ind.heat_mode));
        $display("test scheme done");
    endtask

    task automatic t_net();
        logic [4:0] p;
        hsm_sup_model_i.wr(`HSM_ADDR_LOCK, 32'h200);
        for (int i = 0; i < 5; i++) begin
            p = 5'h01 << i;
            hsm_sup_model_i.wr(`HSM_ADDR_NET_OUT, {27'h0, p});
            settle();
            chk("outputs", {27'h0, p}, {27'h0, outs});
            chk("active", 32'(|p[4:1]), 32'(ind.active));
            chk("stage one", 32'(p[4] | p[2]), 32'(ind.stage1));
            chk("stage two", 32'(p[3] | p[1]), 32'(ind.stage2));
        end
        hsm_sup_model_i.wr(`HSM_ADDR_NET_OUT, 32'h0);
        hsm_sup_model_i.wr(`HSM_ADDR_LOCK, 32'h0);
        $display("test network outputs done");
    endtask

    task automatic t_heat_fan();
        hsm_sup_model_i.wr(`HSM_ADDR_SYS_MODE, 32'h1);
        hsm_sup_model_i.set_temp(16'h0050);
        settle();
        chk("heat mode", 32'h1, 32'(ind.heat_mode));
        chk("outputs", 32'h06, {27'h0, outs});
        hsm_sup_model_i.wr(`HSM_ADDR_HEAT_FAN, 32'h1);
        settle();
        chk("heat fan", 32'h1, 32'(outs.fan));
        hsm_sup_model_i.set_temp(16'h0200);
        settle();
        chk("manual hold", 32'h1, 32'(ind.heat_mode));
        chk("outputs", 32'h01, {27'h0, outs});
        $display("test heat fan done");
    endtask

    task automatic t_auto();
        hsm_sup_model_i.wr(`HSM_ADDR_SCHEME, 32'h1);
        settle();
        chk("cool mode", 32'h0, 32'(ind.heat_mode));
        chk("cool stages", 32'h3, {30'h0, outs.cool1, outs.cool2});
        hsm_sup_model_i.set_temp(16'h0050);
        settle();
        chk("heat mode", 32'h1, 32'(ind.heat_mode));
        hsm_sup_model_i.set_temp(16'h00E0);
        $display("test auto changeover done");
    endtask

    task automatic t_fan_and_temp();
        hsm_sup_model_i.press(5'h08);
        rchk(`HSM_ADDR_FAN_MODE, 32'h2);
        chk("auto icon", 32'h0, 32'(ind.auto_icon));
        chk("fan", 32'h1, 32'(outs.fan));
        hsm_sup_model_i.press(5'h08);
        rchk(`HSM_ADDR_FAN_MODE, 32'h1);
        hsm_sup_model_i.wr(`HSM_ADDR_SHOWN, 32'h0);
        settle();
        chk("shown", 32'hE0, 32'(shown));
        hsm_sup_model_i.wr(`HSM_ADDR_SHOWN, 32'h1);
        settle();
        chk("shown", 32'hD2, 32'(shown));
        hsm_sup_model_i.wr(`HSM_ADDR_ASSIGNED, 32'hE5);
        rchk(`HSM_ADDR_CUR_TEMP, 32'hE0);
        hsm_sup_model_i.beat();
        settle();
        rchk(`HSM_ADDR_CUR_TEMP, 32'hE5);
        $display("test fan and temperature done");
    endtask

    task automatic t_occ();
        hsm_sup_model_i.wr(`HSM_ADDR_LOCK, 32'hA);
        hsm_sup_model_i.press(5'h10);
        hsm_sup_model_i.press(5'h04);
        hsm_sup_model_i.press(5'h01);
        hsm_sup_model_i.press(5'h02);
        hsm_sup_model_i.press(5'h01);
        settle();
        chk("locked", 32'h0, {30'h0, ind.vent, ind.unocc});
        hsm_sup_model_i.wr(`HSM_ADDR_LOCK, 32'h0);
        hsm_sup_model_i.press(5'h01);
        hsm_sup_model_i.press(5'h02);
        hsm_sup_model_i.press(5'h01);
        settle();
        chk("unocc", 32'h1, 32'(ind.unocc));
        chk("shown", 32'hB4, 32'(shown));
        hsm_sup_model_i.wr(`HSM_ADDR_UNOCC_HEAT, 32'hC8);
        settle();
        chk("shown", 32'hC8, 32'(shown));
        rchk(`HSM_ADDR_STATUS, 32'hE3C);
        $display("test occupancy done");
    endtask

    initial begin
        repeat (100000) @(posedge i_core_clk);
        num_errors++;
        close_out();
    end

    initial begin
        i_rst = 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        #1;
        t_reset();
        t_scheme();
        t_net();
        t_heat_fan();
        t_auto();
        t_fan_and_temp();
        t_occ();
        close_out();
    end
endmodule // tb_hsm_stage_mode_ctrl

bind hsm_stage_mode_ctrl hsm_stage_mode_ctrl_checker hsm_stage_mode_ctrl_checker_i (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_outs(o_outs), .o_ind(o_ind));
